/* File: pkg/compass_pkg.sv */
/*
 pin-level sequencing constants and carriers for the three-axis sensor readout core.
 assumes a single 100 MHz clock and an analog front end that answers sample requests.
*/
package compass_pkg;
   // ****************
   // timing
   // ****************
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_LOW_US = 200;
   // more than the figure: one cycle beyond the exact count
   localparam int PULSE_LOW_CYC = (PULSE_LOW_US * 1000) / CLK_PERIOD_NS + 1;
   localparam int PULSE_CNT_W = 15;
   localparam int SAMPLE_W = 12;
   localparam int RESULT_W = 16;
   // pin synchroniser reset: chip select and data idle high, so no false select
   localparam logic [4:0] PIN_SYNC_IDLE = 5'h05;

   // ****************
   // measurement configuration codes
   // ****************
   localparam logic [1:0] MEAS_NORMAL = 2'h0;
   localparam logic [1:0] MEAS_POS_BIAS = 2'h1;
   localparam logic [1:0] MEAS_NEG_BIAS = 2'h2;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SET = 7'h02,
      ST_SAMP1 = 7'h04,
      ST_PREP2 = 7'h08,
      ST_SAMP2 = 7'h10,
      ST_STORE = 7'h20,
      ST_DONE = 7'h40
   } seq_state_e;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] x;
      logic signed [SAMPLE_W-1:0] y;
      logic signed [SAMPLE_W-1:0] z;
   } axis_sample_s;

   typedef struct packed {
      logic signed [RESULT_W-1:0] x;
      logic signed [RESULT_W-1:0] y;
      logic signed [RESULT_W-1:0] z;
   } axis_result_s;
endpackage : compass_pkg

/* File: design/compass_self_test_pins.sv */
/*
 measurement sequencer, result register and pin steering of the sensor readout core.
 assumes the analog front end returns all three axis samples with sample_valid after a request,
 and that a serial engine elsewhere consumes the steered pin signals.
*/
`timescale 1ns/1ps
module compass_self_test_pins (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // pins
   input wire logic conv_trigger,
   input wire logic if_select,
   input wire logic chip_sel_n,
   input wire logic sclk_pin,
   input wire logic sdata_in,
   output logic sdata_out,
   output logic sdata_oe_n,
   output logic sdo_pin,
   output logic result_pulse_n,
   // configuration from the register block
   input wire logic [1:0] meas_config_bits,
   input wire logic three_wire_select,
   input wire logic meas_request,
   // serial engine side
   output logic i2c_mode,
   output logic ser_clk,
   output logic ser_data_in,
   output logic ser_select,
   input wire logic ser_tx_data,
   input wire logic ser_tx_en,
   // analog front end
   output logic strap_cap_drive,
   output logic strap_cap_pos,
   output logic bias_enable,
   output logic bias_negative,
   output logic sample_req,
   input wire logic sample_valid,
   input wire compass_pkg::axis_sample_s sample_in,
   // results
   output compass_pkg::axis_result_s result_out,
   output logic result_update
);
   import compass_pkg::*;

   // ****************
   // reset release and pin synchronisers
   // ****************
   logic [1:0] rst_sync_reg;
   logic rst_i_n;
   logic [4:0] pin_s1_reg, pin_s2_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_i_n = rst_sync_reg[1];

   always_ff @(posedge sys_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pin_s1_reg <= PIN_SYNC_IDLE;
         pin_s2_reg <= PIN_SYNC_IDLE;
      end else begin
         pin_s1_reg <= {conv_trigger, if_select, chip_sel_n, sclk_pin, sdata_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // ****************
   // serial pin steering
   // ****************
   logic trig_s, sel_s, cs_n_s;
   assign trig_s = pin_s2_reg[4];
   assign sel_s = pin_s2_reg[3];
   assign cs_n_s = pin_s2_reg[2];
   assign i2c_mode = sel_s;
   assign ser_clk = pin_s2_reg[1];
   assign ser_data_in = pin_s2_reg[0];
   // chip select only qualifies SPI; in I2C it is held high and ignored
   assign ser_select = sel_s ? 1'b1 : !cs_n_s;

   logic sda_drive, sdo_drive;
   always_comb begin
      sda_drive = 1'b0;
      sdo_drive = 1'b0;
      if (sel_s) begin
         sda_drive = ser_tx_en && !ser_tx_data; // open drain in I2C
      end else if (!cs_n_s && ser_tx_en) begin
         if (three_wire_select) begin
            sda_drive = 1'b1;
         end else begin
            sdo_drive = 1'b1;
         end
      end
   end
   assign sdata_oe_n = !sda_drive;
   assign sdata_out = sel_s ? 1'b0 : ser_tx_data;
   assign sdo_pin = sdo_drive ? ser_tx_data : 1'b1;

   // ****************
   // measurement sequencer
   // ****************
   seq_state_e state_reg, state_next;
   logic trig_prev_reg, trig_prev_next;
   logic self_test_reg, self_test_next;
   logic neg_reg, neg_next;
   axis_sample_s first_reg, first_next;
   axis_result_s result_reg, result_next;
   logic update_reg, update_next;
   logic start;

   function automatic logic signed [RESULT_W-1:0] axis_calc(
      input logic signed [SAMPLE_W-1:0] a, input logic signed [SAMPLE_W-1:0] b,
      input logic halve);
      logic signed [RESULT_W-1:0] d;
      d = RESULT_W'(b) - RESULT_W'(a);
      axis_calc = halve ? (d >>> 1) : d;
   endfunction : axis_calc

   assign start = (trig_s && !trig_prev_reg) || meas_request;

   always_comb begin
      state_next = state_reg;
      trig_prev_next = trig_s;
      self_test_next = self_test_reg;
      neg_next = neg_reg;
      first_next = first_reg;
      result_next = result_reg;
      update_next = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (start) begin
               self_test_next = (meas_config_bits == MEAS_POS_BIAS) ||
                                (meas_config_bits == MEAS_NEG_BIAS);
               neg_next = (meas_config_bits == MEAS_NEG_BIAS);
               state_next = ST_SET;
            end
         end
         ST_SET: state_next = ST_SAMP1;
         ST_SAMP1: begin
            if (sample_valid) begin
               first_next = sample_in;
               state_next = ST_PREP2;
            end
         end
         ST_PREP2: state_next = ST_SAMP2;
         ST_SAMP2: begin
            if (sample_valid) begin
               // self test: second - first, whole normal: (set - reset)/2
               result_next.x = self_test_reg ? axis_calc(first_reg.x, sample_in.x, 1'b0)
                                             : axis_calc(sample_in.x, first_reg.x, 1'b1);
               result_next.y = self_test_reg ? axis_calc(first_reg.y, sample_in.y, 1'b0)
                                             : axis_calc(sample_in.y, first_reg.y, 1'b1);
               result_next.z = self_test_reg ? axis_calc(first_reg.z, sample_in.z, 1'b0)
                                             : axis_calc(sample_in.z, first_reg.z, 1'b1);
               state_next = ST_STORE;
            end
         end
         ST_STORE: begin
            update_next = 1'b1;
            state_next = ST_DONE;
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         state_reg <= ST_IDLE;
         trig_prev_reg <= 1'b0;
         self_test_reg <= 1'b0;
         neg_reg <= 1'b0;
         first_reg <= '0;
         result_reg <= '0;
         update_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         trig_prev_reg <= trig_prev_next;
         self_test_reg <= self_test_next;
         neg_reg <= neg_next;
         first_reg <= first_next;
         result_reg <= result_next;
         update_reg <= update_next;
      end
   end

   // set pulse in ST_SET; reset pulse before the second normal sample
   assign strap_cap_drive = (state_reg == ST_SET) ||
                            (state_reg == ST_PREP2 && !self_test_reg);
   assign strap_cap_pos = (state_reg == ST_SET);
   assign bias_enable = self_test_reg && (state_reg == ST_PREP2 || state_reg == ST_SAMP2);
   assign bias_negative = neg_reg;
   assign sample_req = (state_reg == ST_SAMP1) || (state_reg == ST_SAMP2);
   assign result_out = result_reg;
   assign result_update = update_reg;

   // ****************
   // result pulse stretcher
   // ****************
   logic [PULSE_CNT_W-1:0] pcnt_reg, pcnt_next;
   always_comb begin
      pcnt_next = pcnt_reg;
      if (update_reg) begin
         pcnt_next = PULSE_CNT_W'(PULSE_LOW_CYC);
      end else if (pcnt_reg != '0) begin
         pcnt_next = pcnt_reg - 1'b1;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pcnt_reg <= '0;
      end else begin
         pcnt_reg <= pcnt_next;
      end
   end
   assign result_pulse_n = (pcnt_reg == '0);

   // ****************
   // checks
   // ****************
   // low-time counter, saturating so a stretched pulse cannot wrap
   logic [PULSE_CNT_W-1:0] low_cnt_reg, low_cnt_next;
   always_comb begin
      low_cnt_next = '0;
      if (!result_pulse_n) begin
         low_cnt_next = (low_cnt_reg == '1) ? low_cnt_reg : low_cnt_reg + 1'b1;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         low_cnt_reg <= '0;
      end else begin
         low_cnt_reg <= low_cnt_next;
      end
   end

   pulse_start_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      update_reg |=> !result_pulse_n) else $error("pulse not started");
   pulse_len_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      $fell(result_pulse_n) |-> (pcnt_reg == PULSE_CNT_W'(PULSE_LOW_CYC)))
      else $error("pulse length wrong");
   pulse_width_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      $rose(result_pulse_n) |-> (low_cnt_reg >= PULSE_CNT_W'(PULSE_LOW_CYC)))
      else $error("pulse too short");
   pulse_high_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      result_pulse_n && !update_reg |=> result_pulse_n) else $error("pulse spurious");
   trig_start_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      (state_reg == ST_IDLE) && trig_s && !trig_prev_reg |=> state_reg == ST_SET)
      else $error("trigger ignored");
   sel_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      i2c_mode |-> ser_select) else $error("i2c select wrong");
   cs_spi_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      !i2c_mode && cs_n_s |-> sdata_oe_n && sdo_pin) else $error("spi drives unselected");
   three_wire_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      !i2c_mode && three_wire_select && !cs_n_s && ser_tx_en |-> !sdata_oe_n)
      else $error("3-wire not driving");
   bias_seq_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      state_reg == ST_SET |-> strap_cap_drive && !bias_enable) else $error("set order");
   st_diff_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      state_reg == ST_SAMP2 && sample_valid && self_test_reg |=>
      result_reg.x == RESULT_W'($past(sample_in.x)) - RESULT_W'(first_reg.x))
      else $error("self test diff");
   config_pick_a: assert property (@(posedge sys_clk) disable iff (!rst_i_n)
      state_reg == ST_IDLE && start && meas_config_bits == MEAS_NORMAL |=> !self_test_reg)
      else $error("config ignored");
endmodule : compass_self_test_pins

/* File: sim/front_end_model.sv */
/* stand-in for the analog front end: answers each sample request with a 3-axis sample.
   assumes the sequencer holds sample_req until it sees sample_valid. */
`timescale 1ns/1ps
module front_end_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // sequencer side
   input wire logic sample_req,
   output logic sample_valid,
   output compass_pkg::axis_sample_s sample_in,
   // samples handed out, baseline then second, and answer delay
   input wire compass_pkg::axis_sample_s first_s,
   input wire compass_pkg::axis_sample_s second_s,
   input wire logic [3:0] resp_delay
);
   import compass_pkg::*;
   logic [3:0] wait_reg;
   logic second_reg;
   axis_sample_s now_s;
   assign now_s = second_reg ? second_s : first_s;
   // off-valid the bus carries the inverse, so a stale sample cannot pass
   assign sample_in = sample_valid ? now_s : ~now_s;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 4'h0;
         sample_valid <= 1'b0;
         second_reg <= 1'b0;
      end else if (sample_valid) begin
         sample_valid <= 1'b0;
         second_reg <= ~second_reg;
         wait_reg <= 4'h0;
      end else if (sample_req) begin
         if (wait_reg == resp_delay) begin
            sample_valid <= 1'b1;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule : front_end_model

/* File: sim/tb_compass_self_test_pins.sv */
/* self-checking bench of the sequencer and pin steering.
   assumes the front end model answers sample requests. */
`timescale 1ns/1ps
module tb_compass_self_test_pins;
   import compass_pkg::*;
   logic sys_clk = 0, rst_n = 0, conv_trigger = 0, if_select = 0, chip_sel_n = 1;
   logic sclk_pin = 0, sdata_in = 0, three_wire_select = 0, meas_request = 0;
   logic ser_tx_data = 0, ser_tx_en = 0, sdata_out, sdata_oe_n, sdo_pin, result_pulse_n;
   logic i2c_mode, ser_clk, ser_data_in, ser_select, strap_cap_drive, strap_cap_pos;
   logic bias_enable, bias_negative, sample_req, sample_valid, result_update;
   logic [1:0] meas_config_bits = 2'h0;
   logic [3:0] resp_delay = 4'h0;
   axis_sample_s sample_in, first_s, second_s;
   axis_result_s result_out;
   int fails = 0, checks_done = 0, cycles = 0;
   compass_self_test_pins compass_self_test_pins_i (.sys_clk, .rst_n, .conv_trigger,
      .if_select, .chip_sel_n, .sclk_pin, .sdata_in, .sdata_out, .sdata_oe_n, .sdo_pin,
      .result_pulse_n, .meas_config_bits, .three_wire_select, .meas_request, .i2c_mode,
      .ser_clk, .ser_data_in, .ser_select, .ser_tx_data, .ser_tx_en, .strap_cap_drive,
      .strap_cap_pos, .bias_enable, .bias_negative, .sample_req, .sample_valid, .sample_in,
      .result_out, .result_update);
   front_end_model front_end_model_i (.sys_clk, .rst_n, .sample_req, .sample_valid,
      .sample_in, .first_s, .second_s, .resp_delay);
   initial forever #5 sys_clk = ~sys_clk;
   // ****************
   // shared tasks
   // ****************
   task automatic tally_and_finish();
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic axis_result_s expect_res(input logic st);
      axis_result_s r;
      r.x = st ? second_s.x - first_s.x : (first_s.x - second_s.x) >>> 1;
      r.y = st ? second_s.y - first_s.y : (first_s.y - second_s.y) >>> 1;
      r.z = st ? second_s.z - first_s.z : (first_s.z - second_s.z) >>> 1;
      return r;
   endfunction : expect_res
   task automatic do_meas(input logic [1:0] cfg, input logic by_trig, input string tag);
      logic sp = 0, be = 0, bn = 0, hi = 1;
      int n = 0, nu = 0, ns = 0;
      meas_config_bits <= cfg;
      @(posedge sys_clk);
      if (by_trig) begin
         conv_trigger <= 1;
      end else begin
         meas_request <= 1;
      end
      @(posedge sys_clk);
      meas_request <= 0;
      repeat (300) begin
         @(posedge sys_clk);
         sp |= strap_cap_drive === 1'b1 && strap_cap_pos === 1'b1;
         be |= bias_enable === 1'b1;
         bn |= bias_negative === 1'b1;
         ns += int'(sample_req === 1'b1);
         if (result_update === 1'b1) break;
      end
      // each of the two samples waits resp_delay plus two cycles in the model
      check({tag, " requests"}, 48'(ns), 48'(2 * resp_delay + 4));
      conv_trigger <= 0; // trigger back to ground when idle
      check({tag, " result"}, result_out, expect_res(cfg != MEAS_NORMAL));
      check({tag, " steps"}, 48'({sp, be, bn}),
            48'({1'b1, cfg != MEAS_NORMAL, cfg == MEAS_NEG_BIAS}));
      repeat (25000) begin
         @(posedge sys_clk);
         nu += int'(result_update === 1'b1);
         if (result_pulse_n === 1'b0) n++;
         else if (n > 0) break;
      end
      check({tag, " pulse"}, 48'(n), 48'(PULSE_LOW_CYC));
      check({tag, " one update"}, 48'(nu), 48'h0);
      repeat (30) begin
         @(posedge sys_clk);
         hi &= result_pulse_n === 1'b1;
      end
      check({tag, " release"}, 48'(hi), 48'h1);
   endtask : do_meas
   // ****************
   // scenarios
   // ****************
   task automatic test_pins();
      if_select <= 1;
      sdata_in <= 1;
      repeat (6) @(posedge sys_clk);
      check("i2c", 48'({i2c_mode, ser_select, ser_data_in}), 48'h7);
      ser_tx_en <= 1;
      repeat (2) @(posedge sys_clk);
      check("i2c drive low", 48'({sdata_oe_n, sdata_out, sdo_pin}), 48'h1);
      ser_tx_data <= 1;
      repeat (2) @(posedge sys_clk);
      check("i2c release", 48'({sdata_oe_n, sdo_pin}), 48'h3);
      ser_tx_data <= 0;
      ser_tx_en <= 0;
      if_select <= 0;
      sclk_pin <= 1;
      repeat (6) @(posedge sys_clk);
      check("spi idle", 48'({i2c_mode, ser_select, ser_clk}), 48'h1);
      chip_sel_n <= 0;
      three_wire_select <= 1;
      ser_tx_en <= 1;
      repeat (6) @(posedge sys_clk);
      check("3wire", 48'({ser_select, sdata_oe_n, sdata_out, sdo_pin}), 48'h9);
      three_wire_select <= 0;
      @(posedge sys_clk);
      @(posedge sys_clk);
      check("4wire", 48'({sdata_oe_n, sdo_pin}), 48'h2);
      chip_sel_n <= 1;
      ser_tx_en <= 0;
      sclk_pin <= 0;
   endtask : test_pins
   task automatic test_normal();
      do_meas(MEAS_NORMAL, 0, "normal");
   endtask : test_normal
   task automatic test_pos_trig();
      resp_delay <= 4'h6;
      do_meas(MEAS_POS_BIAS, 1, "pos trig");
   endtask : test_pos_trig
   task automatic test_neg();
      resp_delay <= 4'h0;
      do_meas(MEAS_NEG_BIAS, 0, "neg");
   endtask : test_neg
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   initial begin
      first_s = '{12'h7f0, 12'h801, 12'h123};
      second_s = '{12'h810, 12'h7ff, 12'hf00};
      repeat (3) @(posedge sys_clk);
      rst_n <= 1;
      repeat (6) @(posedge sys_clk);
      test_pins();
      test_normal();
      test_pos_trig();
      test_neg();
      tally_and_finish();
   end
endmodule : tb_compass_self_test_pins
